// File: hw/divided_ref_output_divider.sv
// Even-ratio clock-out divider with 50:50 duty.
// Assumes one reference tick enable per reference period.
`timescale 1ns/1ps
module divided_ref_output_divider (
   input  wire logic MCLK,
   input  wire logic RST_N,
   clkdiv_if.div     dv
);
   logic [3:0] cnt_r;
   logic [3:0] active_r;
   logic       level_r;
   logic       term;

   assign term      = (cnt_r == active_r - 4'h1);
   assign dv.level  = level_r;
   assign dv.active = active_r;

   // ==========================================================
   // Half period of k ticks gives ratio 2k
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         cnt_r    <= 4'h0;
         level_r  <= 1'b0;
         active_r <= synth_cfg_pkg::DIVF_RST;
      end else if (!dv.ce) begin
         cnt_r    <= 4'h0;
         level_r  <= 1'b0;
         active_r <= synth_cfg_pkg::DIVF_RST; // RULE9
      end else if (dv.ref_tick) begin
         if (term) begin
            cnt_r   <= 4'h0;
            level_r <= ~level_r; // RULE8
            // Ratio swaps only after a full low half: no runt pulses
            if (!level_r && dv.field != 4'h0) begin
               active_r <= dv.field; // RULE15 RULE16
            end
         end else begin
            cnt_r <= cnt_r + 4'h1; // RULE7
         end
      end
   end
endmodule // divided_ref_output_divider

// File: hw/ref_clock_cfg.sv
// Reference clock and frequency word control with Avalon-MM registers.
// Assumes MCLK is the crystal reference and all inputs are synchronous.
//
// Design decisions made here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps

// What this block does
// RULE1 - Output is phase comparator times N plus fraction/4096
// RULE2 - Oscillator runs while disable bit low; resets low
// RULE3 - Chip enable low stops the oscillator
// RULE4 - Disable bit high selects external square reference
// RULE5 - Fine correction modulus fixed at 2^15 steps
// RULE6 - Correction word is signed two's complement
// RULE7 - Clock output divides by even 2 to 30
// RULE8 - Clock output has equal high and low
// RULE9 - Divide ratio 16 after power-up
// RULE10 - Output buffer driven while enable bit high
// RULE11 - Both varactor bits high reduce capacitance
// RULE12 - Host avoids bias 0x0, 0xE, 0xF
// RULE13 - Host uses bias 0x5 as safe default
// RULE14 - Chip enable low returns the freq, ref and function registers to their reset values
// RULE15 - Field value k gives ratio 2k; a field of 0 is ignored and keeps the previous ratio
// RULE16 - Ratio changes only at period boundary
module ref_clock_cfg #(
   parameter int INT_W = 8
) (
   input  wire logic        MCLK,
   input  wire logic        RST_N,
   input  wire logic        CHIP_EN,
   input  wire logic        REF_INPUT_PIN,
   input  wire logic [4:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic      [31:0] AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   output logic             OSC_ENABLE,
   output logic             REF_SELECT_EXT,
   output logic             DIVIDED_REF_OUTPUT,
   output logic             DIVIDED_REF_OUTPUT_DRIVE,
   output logic             VARACTOR_REDUCED,
   output logic      [3:0]  VCO_BIAS,
   output logic      [31:0] SYNTH_WORD
);

   // ==========================================================
   // Functions
   function automatic logic [31:0] be_merge(
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0]  be
   );
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction

   // Word on a 2^15 grid: N, fraction and signed fine offset
   function automatic logic [31:0] synth_calc(
      input logic [INT_W-1:0] n_int,
      input logic [11:0]      frac,
      input logic [10:0]      fec
   );
      logic [31:0] base;
      logic [31:0] fine;
      base = (32'(n_int) << synth_cfg_pkg::FINE_SHIFT)
           + (32'(frac) << synth_cfg_pkg::FRAC_SHIFT); // RULE1
      fine = {{21{fec[10]}}, fec}; // RULE6
      return base + fine; // RULE5
   endfunction

   function automatic logic bias_unsafe(input logic [3:0] b);
      return (b == synth_cfg_pkg::BIAS_BAD0)
          || (b == synth_cfg_pkg::BIAS_BADE)
          || (b == synth_cfg_pkg::BIAS_BADF);
   endfunction

   // ==========================================================
   // Registers
   logic [31:0]                  freq_r;
   logic [31:0]                  ref_r;
   logic [31:0]                  func_r;
   logic [31:0]                  freq_nxt;
   logic [31:0]                  ref_nxt;
   logic [31:0]                  func_nxt;
   synth_cfg_pkg::bus_state_type bus_r;
   logic                         ref_prev_r;
   logic                         req;
   logic                         commit_wr;
   logic                         ext_ref;
   logic [31:0]                  rd_val;
   logic [31:0]                  status;

   clkdiv_if dvi ();

   divided_ref_output_divider u_div (
      .MCLK  (MCLK),
      .RST_N (RST_N),
      .dv    (dvi.div)
   );

   assign req       = AVS_READ | AVS_WRITE;
   // Write lands on the edge where the master sees waitrequest low
   assign commit_wr = AVS_WRITE && bus_r == synth_cfg_pkg::BUS_ACK
                      && CHIP_EN;
   assign ext_ref   = func_r[synth_cfg_pkg::OSC_DIS_BIT];

   assign freq_nxt = be_merge(freq_r, AVS_WRITEDATA, AVS_BYTEENABLE);
   assign ref_nxt  = be_merge(ref_r, AVS_WRITEDATA, AVS_BYTEENABLE);
   assign func_nxt = be_merge(func_r, AVS_WRITEDATA, AVS_BYTEENABLE);

   // ==========================================================
   // Reference tick into the divider
   assign dvi.ce    = CHIP_EN;
   assign dvi.field = ref_r[synth_cfg_pkg::DIVF_LSB +: 4];
   // Crystal ticks every clock; external ref ticks on its rising edge
   always_comb begin
      if (!CHIP_EN) begin
         dvi.ref_tick = 1'b0; // RULE3
      end else if (ext_ref) begin
         dvi.ref_tick = REF_INPUT_PIN & ~ref_prev_r; // RULE4
      end else begin
         dvi.ref_tick = 1'b1; // RULE2
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         ref_prev_r <= 1'b0;
      end else begin
         ref_prev_r <= REF_INPUT_PIN;
      end
   end

   // ==========================================================
   // Frequency register
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         freq_r <= 32'h0000_0000;
      end else if (!CHIP_EN) begin
         freq_r <= 32'h0000_0000; // RULE14
      end else if (commit_wr && AVS_ADDRESS == synth_cfg_pkg::OFF_FREQ)
      begin
         freq_r <= freq_nxt & {{(20-INT_W){1'b0}}, {(INT_W){1'b1}}, 12'hFFF};
      end
   end

   // ==========================================================
   // Reference register
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         ref_r <= 32'(synth_cfg_pkg::DIVF_RST) << synth_cfg_pkg::DIVF_LSB;
      end else if (!CHIP_EN) begin
         ref_r <= 32'(synth_cfg_pkg::DIVF_RST)
                  << synth_cfg_pkg::DIVF_LSB; // RULE14 RULE9
      end else if (commit_wr && AVS_ADDRESS == synth_cfg_pkg::OFF_REF)
      begin
         ref_r <= ref_nxt & 32'h01F8_07FF;
      end
   end

   // ==========================================================
   // Function register
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         func_r <= (32'(synth_cfg_pkg::BIAS_RST) << synth_cfg_pkg::BIAS_LSB)
                 | (32'(synth_cfg_pkg::BUF_EN_RST)
                    << synth_cfg_pkg::BUF_EN_BIT);
      end else if (!CHIP_EN) begin
         func_r <= (32'(synth_cfg_pkg::BIAS_RST) << synth_cfg_pkg::BIAS_LSB)
                 | (32'(synth_cfg_pkg::BUF_EN_RST)
                    << synth_cfg_pkg::BUF_EN_BIT); // RULE14 RULE10
      end else if (commit_wr && AVS_ADDRESS == synth_cfg_pkg::OFF_FUNC)
      begin
         func_r <= func_nxt & 32'h0000_0F11;
      end
   end

   // ==========================================================
   // Read mux
   assign status = {23'h000000,
                    bias_unsafe(func_r[synth_cfg_pkg::BIAS_LSB +: 4]),
                    dvi.active,
                    dvi.level,
                    VARACTOR_REDUCED,
                    REF_SELECT_EXT,
                    OSC_ENABLE};

   always_comb begin
      if (AVS_ADDRESS == synth_cfg_pkg::OFF_FREQ) begin
         rd_val = freq_r;
      end else if (AVS_ADDRESS == synth_cfg_pkg::OFF_REF) begin
         rd_val = ref_r;
      end else if (AVS_ADDRESS == synth_cfg_pkg::OFF_FUNC) begin
         rd_val = func_r;
      end else if (AVS_ADDRESS == synth_cfg_pkg::OFF_STATUS) begin
         rd_val = status;
      end else if (AVS_ADDRESS == synth_cfg_pkg::OFF_SYNTH) begin
         rd_val = SYNTH_WORD;
      end else begin
         rd_val = 32'h0000_0000;
      end
   end

   // ==========================================================
   // Avalon handshake: one wait state, then release
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         bus_r           <= synth_cfg_pkg::BUS_IDLE;
         AVS_WAITREQUEST <= 1'b1;
         AVS_READDATA    <= 32'h0000_0000;
      end else begin
         case (bus_r)
            synth_cfg_pkg::BUS_IDLE: begin
               if (req) begin
                  bus_r           <= synth_cfg_pkg::BUS_ACK;
                  AVS_WAITREQUEST <= 1'b0;
                  AVS_READDATA    <= AVS_READ ? rd_val : 32'h0000_0000;
               end
            end
            synth_cfg_pkg::BUS_ACK: begin
               bus_r           <= synth_cfg_pkg::BUS_IDLE;
               AVS_WAITREQUEST <= 1'b1;
            end
            default: begin
               bus_r           <= synth_cfg_pkg::BUS_IDLE;
               AVS_WAITREQUEST <= 1'b1;
            end
         endcase
      end
   end

   // ==========================================================
   // Outputs
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         OSC_ENABLE         <= 1'b0;
         REF_SELECT_EXT     <= 1'b0;
         DIVIDED_REF_OUTPUT <= 1'b0;
         DIVIDED_REF_OUTPUT_DRIVE       <= 1'b0;
         VARACTOR_REDUCED   <= 1'b0;
         VCO_BIAS           <= synth_cfg_pkg::BIAS_RST;
         SYNTH_WORD         <= 32'h0000_0000;
      end else begin
         OSC_ENABLE <= CHIP_EN && !ext_ref; // RULE2 RULE3
         REF_SELECT_EXT <= CHIP_EN && ext_ref; // RULE4
         DIVIDED_REF_OUTPUT_DRIVE <= CHIP_EN
                         && func_r[synth_cfg_pkg::BUF_EN_BIT]; // RULE10
         // Low when undriven so the host never sees a stale level
         DIVIDED_REF_OUTPUT <= CHIP_EN && dvi.level
                               && func_r[synth_cfg_pkg::BUF_EN_BIT]; // RULE10
         VARACTOR_REDUCED <= ref_r[synth_cfg_pkg::VA_LOW_BIT]
                             && ref_r[synth_cfg_pkg::VA_HIGH_BIT]; // RULE11
         // Bias passed as written; the unsafe flag is status only
         VCO_BIAS <= func_r[synth_cfg_pkg::BIAS_LSB +: 4]; // RULE12 RULE13
         SYNTH_WORD <= synth_calc(
            freq_r[synth_cfg_pkg::INT_LSB +: INT_W],
            freq_r[synth_cfg_pkg::FRAC_LSB +: 12],
            ref_r[synth_cfg_pkg::FEC_LSB +: 11]); // RULE1 RULE5 RULE6
      end
   end

endmodule // ref_clock_cfg

// File: pkg/clkdiv_if.sv
// Carrier between the config block and its clock-out divider.
// Both ends run on the one block clock.
`timescale 1ns/1ps
interface clkdiv_if;
   logic       ce;
   logic       ref_tick;
   logic [3:0] field;
   logic       level;
   logic [3:0] active;

   modport ctl (output ce, output ref_tick, output field,
                input level, input active);
   modport div (input ce, input ref_tick, input field,
                output level, output active);
endinterface

// File: pkg/synth_cfg_pkg.sv
// Constants shared by the reference clock and synthesizer config block.
// Assumes a 32-bit Avalon-MM slave with byte addresses.
package synth_cfg_pkg;

   // ==========================================================
   // Register byte offsets
   localparam logic [4:0] OFF_FREQ   = 5'h00;
   localparam logic [4:0] OFF_REF    = 5'h04;
   localparam logic [4:0] OFF_FUNC   = 5'h08;
   localparam logic [4:0] OFF_STATUS = 5'h0C;
   localparam logic [4:0] OFF_SYNTH  = 5'h10;

   // ==========================================================
   // Field positions
   localparam int FRAC_LSB    = 0;   // fraction_word [11:0]
   localparam int FRAC_W      = 12;
   localparam int INT_LSB     = 12;  // integer divide [19:12]
   localparam int FEC_LSB     = 0;   // freq_error_correction_word [10:0]
   localparam int FEC_W       = 11;
   localparam int DIVF_LSB    = 19;  // divided_ref_output_divide_field [22:19]
   localparam int DIVF_W      = 4;
   localparam int VA_LOW_BIT  = 23;
   localparam int VA_HIGH_BIT = 24;
   localparam int OSC_DIS_BIT = 0;
   localparam int BUF_EN_BIT  = 4;
   localparam int BIAS_LSB    = 8;   // vco_bias_field [11:8]
   localparam int BIAS_W      = 4;
   localparam int FINE_SHIFT  = 15;  // fine modulus 2^15
   localparam int FRAC_SHIFT  = 3;   // 2^12 fraction on a 2^15 grid

   // ==========================================================
   // Values after reset, and the unsafe bias codes
   localparam logic [3:0] DIVF_RST   = 4'h8;  // ratio 16
   localparam logic       BUF_EN_RST = 1'b1;
   localparam logic       OSC_DIS_RST = 1'b0;
   localparam logic [3:0] BIAS_RST   = 4'h5;
   localparam logic [3:0] BIAS_BAD0  = 4'h0;
   localparam logic [3:0] BIAS_BADE  = 4'hE;
   localparam logic [3:0] BIAS_BADF  = 4'hF;

   // ==========================================================
   // Bus handshake states, Gray order
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACK  = 2'b01,
      BUS_DONE = 2'b11
   } bus_state_type;

endpackage

// File: verif/host_mcu_model.sv
// Host model clocked by the divided reference output.
// Assumes a free-running square reference on the same MCLK grid.
`timescale 1ns/1ps
module host_mcu_model #(
   parameter int HALF = 2
) (
   input  wire logic mclk,
   input  wire logic clk_div,
   output logic      ref_sq,
   output int        rises,
   output int        hi_len,
   output int        lo_len
);
   int   cnt = 0;
   int   run = 0;
   logic last = 1'b0;

   initial begin
      ref_sq = 1'b0;
      rises = 0;
      hi_len = 0;
      lo_len = 0;
   end
   // Runs free like an oscillator module, selected or not
   always @(posedge mclk) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) ref_sq <= !ref_sq;
   end
   // Half lengths in MCLK cycles, as the host would see them
   always @(posedge mclk) begin
      if (clk_div == last) begin
         run <= run + 1;
      end else begin
         if (last) hi_len <= run;
         else lo_len <= run;
         run <= 1;
      end
      last <= clk_div;
   end
   always @(posedge clk_div) rises <= rises + 1;
endmodule // host_mcu_model

// File: verif/ref_clock_cfg_props.sv
// Port-level checks for the reference clock and synth config block.
// Assumes one MCLK domain; bound into ref_clock_cfg below.
`timescale 1ns/1ps
module ref_clock_cfg_props (
   input wire logic        MCLK,
   input wire logic        RST_N,
   input wire logic        CHIP_EN,
   input wire logic [4:0]  AVS_ADDRESS,
   input wire logic        AVS_READ,
   input wire logic        AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0]  AVS_BYTEENABLE,
   input wire logic        AVS_WAITREQUEST,
   input wire logic        OSC_ENABLE,
   input wire logic        REF_SELECT_EXT,
   input wire logic        DIVIDED_REF_OUTPUT,
   input wire logic        DIVIDED_REF_OUTPUT_DRIVE,
   input wire logic        VARACTOR_REDUCED,
   input wire logic [3:0]  VCO_BIAS
);
   logic       wr_func, wr_ref, rise_seen, hi_ok;
   logic [7:0] run, hi_len;
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   assign wr_func = AVS_WRITE && !AVS_WAITREQUEST && CHIP_EN &&
                    AVS_ADDRESS == synth_cfg_pkg::OFF_FUNC;
   assign wr_ref = AVS_WRITE && !AVS_WAITREQUEST && CHIP_EN &&
                   AVS_ADDRESS == synth_cfg_pkg::OFF_REF;
   // ==========================================================
   // Half lengths, trusted only over an unbroken single-source run
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         run <= 8'h00;
         hi_len <= 8'h00;
         rise_seen <= 1'b0;
         hi_ok <= 1'b0;
      end else begin
         run <= $changed(DIVIDED_REF_OUTPUT) ? 8'h01 : run + 8'h01;
         // A half cut by buffer enable must not count as a full one
         if (!DIVIDED_REF_OUTPUT_DRIVE || $rose(DIVIDED_REF_OUTPUT_DRIVE)
             || $changed(REF_SELECT_EXT)) begin
            rise_seen <= 1'b0;
            hi_ok <= 1'b0;
         end else if ($rose(DIVIDED_REF_OUTPUT)) begin
            rise_seen <= 1'b1;
         end else if ($fell(DIVIDED_REF_OUTPUT)) begin
            hi_len <= run;
            hi_ok <= rise_seen;
         end
      end
   end
   // ==========================================================
   // Assertions
   sequence bus_pending;
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
   endsequence
   sequence ack_pulse;
      ##[0:3] !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
   endsequence
   bus_ack_a: assert property (bus_pending |-> ack_pulse)
      else $error("bus ack missing or too long");
   osc_excl_a: assert property (!(OSC_ENABLE && REF_SELECT_EXT))
      else $error("both references selected");
   ce_osc_a: assert property (!CHIP_EN |-> ##[1:2] !OSC_ENABLE)
      else $error("oscillator runs with chip disabled");
   ce_buf_a: assert property (!CHIP_EN |-> ##[1:2] !DIVIDED_REF_OUTPUT_DRIVE)
      else $error("buffer drives with chip disabled");
   out_gate_a: assert property (DIVIDED_REF_OUTPUT |-> DIVIDED_REF_OUTPUT_DRIVE)
      else $error("clock out high with buffer off");
   half_equal_a: assert property ($rose(DIVIDED_REF_OUTPUT) && hi_ok
      |-> run == hi_len) else $error("unequal clock out halves");
   osc_sel_a: assert property (wr_func && AVS_BYTEENABLE[0] |->
      ##2 OSC_ENABLE == !$past(AVS_WRITEDATA[0], 2)
      && REF_SELECT_EXT == $past(AVS_WRITEDATA[0], 2))
      else $error("reference select ignores disable bit");
   buf_drv_a: assert property (wr_func && AVS_BYTEENABLE[0] |->
      ##2 DIVIDED_REF_OUTPUT_DRIVE == $past(AVS_WRITEDATA[4], 2))
      else $error("buffer ignores enable bit");
   var_sel_a: assert property (wr_ref && AVS_BYTEENABLE[3:2] == 2'h3 |->
      ##2 VARACTOR_REDUCED == &$past(AVS_WRITEDATA[24:23], 2))
      else $error("varactor select wrong");
   bias_a: assert property (wr_func && AVS_BYTEENABLE[1] |->
      ##2 VCO_BIAS == $past(AVS_WRITEDATA[11:8], 2))
      else $error("bias field not passed on");
endmodule // ref_clock_cfg_props

bind ref_clock_cfg ref_clock_cfg_props props (
   .MCLK(MCLK), .RST_N(RST_N), .CHIP_EN(CHIP_EN),
   .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
   .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
   .AVS_WAITREQUEST(AVS_WAITREQUEST), .OSC_ENABLE(OSC_ENABLE),
   .REF_SELECT_EXT(REF_SELECT_EXT), .DIVIDED_REF_OUTPUT(DIVIDED_REF_OUTPUT),
   .DIVIDED_REF_OUTPUT_DRIVE(DIVIDED_REF_OUTPUT_DRIVE), .VARACTOR_REDUCED(VARACTOR_REDUCED),
   .VCO_BIAS(VCO_BIAS));

// File: verif/tb_ref_clock_cfg.sv
// Self-checking bench for the reference clock and synth config block.
// Assumes the host model rides on the divided clock output.
`timescale 1ns/1ps
module tb_ref_clock_cfg;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic        chip_en = 1'b1;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [4:0]  adr = 5'h00;
   logic [31:0] wdat = 32'h0000_0000;
   logic [3:0]  be = 4'hF;
   logic [31:0] rdat, synth, q;
   logic [3:0]  bias;
   logic        ref_pin, waitreq, osc_en, ext_sel, div_out, drive, va_red;
   int          hi_len, lo_len, rises;
   int          fail_count = 0;
   int          samples_checked = 0;
   // Order: osc, ext, drive, varactor, bias
   wire logic [7:0] pst = {osc_en, ext_sel, drive, va_red, bias};

   always #10 mclk = ~mclk;
   ref_clock_cfg uut (
      .MCLK(mclk), .RST_N(rst_n), .CHIP_EN(chip_en), .REF_INPUT_PIN(ref_pin),
      .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat),
      .AVS_BYTEENABLE(be), .AVS_READDATA(rdat), .AVS_WAITREQUEST(waitreq),
      .OSC_ENABLE(osc_en), .REF_SELECT_EXT(ext_sel), .SYNTH_WORD(synth),
      .DIVIDED_REF_OUTPUT(div_out), .DIVIDED_REF_OUTPUT_DRIVE(drive),
      .VARACTOR_REDUCED(va_red), .VCO_BIAS(bias));
   host_mcu_model host (
      .mclk(mclk), .clk_div(div_out), .ref_sq(ref_pin), .rises(rises),
      .hi_len(hi_len), .lo_len(lo_len));
   // ==========================================================
   // Bus and compare tasks
   task automatic bus(input logic [4:0] a, input logic w,
                      input logic [31:0] d, input logic [3:0] e);
      adr <= a;
      wr <= w;
      rd <= !w;
      wdat <= d;
      be <= e;
      @(posedge mclk);
      // No local limit: only the watchdog ends a stalled access
      while (waitreq !== 1'b0) begin
         @(posedge mclk);
      end
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [4:0] a, input logic [31:0] d);
      bus(a, 1'b1, d, 4'hF);
   endtask
   task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 32'h0000_0000, 4'hF);
      chk(q, exp);
   endtask
   // Three host clock rises, then two cycles for the lengths to land
   task automatic div_chk(input int half);
      int r0;
      int n;
      r0 = rises;
      n = 0;
      while (rises < r0 + 3 && n < 1000) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 1000) begin
         fail_count++;
         $display("MISMATCH t=%0t clock out stalled", $time);
      end
      repeat (2) @(posedge mclk);
      chk(32'(hi_len), 32'(half));
      chk(32'(lo_len), 32'(half));
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset;
      chk(32'(pst), 32'h0000_00A5);
      rchk(synth_cfg_pkg::OFF_FUNC, 32'h0000_0510);
      rchk(synth_cfg_pkg::OFF_REF, 32'h0040_0000);
      div_chk(8);
      rchk(5'h14, 32'h0000_0000);
   endtask
   task automatic t_divide;
      int ks[3] = '{1, 15, 2};
      foreach (ks[i]) begin
         wreg(synth_cfg_pkg::OFF_REF, 32'(ks[i]) << 19);
         div_chk(ks[i]);
      end
      wreg(synth_cfg_pkg::OFF_REF, 32'h0000_0000);
      div_chk(2);
   endtask
   task automatic t_synth;
      logic [7:0]  nv[2] = '{8'h03, 8'hFF};
      logic [11:0] fv[2] = '{12'h801, 12'hFFF};
      logic [10:0] cv[2] = '{11'h7DC, 11'h3FF};
      logic [31:0] e;
      for (int i = 0; i < 2; i++) begin
         e = ({24'h0, nv[i]} << 15) + ({20'h0, fv[i]} << 3)
             + {{21{cv[i][10]}}, cv[i]};
         wreg(synth_cfg_pkg::OFF_FREQ, {12'h000, nv[i], fv[i]});
         wreg(synth_cfg_pkg::OFF_REF, 32'h0010_0000 | {21'h0, cv[i]});
         repeat (2) @(posedge mclk);
         chk(synth, e);
         wreg(synth_cfg_pkg::OFF_SYNTH, 32'h0000_0000);
         rchk(synth_cfg_pkg::OFF_SYNTH, e);
      end
   endtask
   task automatic t_varactor;
      for (int v = 0; v < 4; v++) begin
         wreg(synth_cfg_pkg::OFF_REF, 32'h0010_0000 | (32'(v) << 23));
         repeat (2) @(posedge mclk);
         chk(32'(va_red), 32'(v == 3));
      end
   endtask
   task automatic t_ext;
      wreg(synth_cfg_pkg::OFF_FUNC, 32'h0000_0511);
      repeat (2) @(posedge mclk);
      chk(32'({osc_en, ext_sel}), 32'h0000_0001);
      div_chk(8);
      wreg(synth_cfg_pkg::OFF_FUNC, 32'h0000_0510);
   endtask
   task automatic t_buf;
      wreg(synth_cfg_pkg::OFF_FUNC, 32'h0000_0500);
      bus(synth_cfg_pkg::OFF_FUNC, 1'b1, 32'hFFFF_0E00, 4'h2);
      repeat (2) @(posedge mclk);
      chk(32'({drive, div_out, bias}), 32'h0000_000E);
      bus(synth_cfg_pkg::OFF_STATUS, 1'b0, 32'h0000_0000, 4'hF);
      chk(q & 32'h0000_0100, 32'h0000_0100);
      wreg(synth_cfg_pkg::OFF_FUNC, 32'h0000_0510);
   endtask
   task automatic t_chip_en;
      chip_en <= 1'b0;
      repeat (3) @(posedge mclk);
      chk(32'({osc_en, drive, div_out}), 32'h0000_0000);
      wreg(synth_cfg_pkg::OFF_FUNC, 32'h0000_0511);
      chip_en <= 1'b1;
      repeat (3) @(posedge mclk);
      rchk(synth_cfg_pkg::OFF_REF, 32'h0040_0000);
      rchk(synth_cfg_pkg::OFF_FUNC, 32'h0000_0510);
      div_chk(8);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (2) @(posedge mclk);
      t_reset;
      t_divide;
      t_synth;
      t_varactor;
      t_ext;
      t_buf;
      t_chip_en;
      report_and_stop;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      report_and_stop;
   end
endmodule // tb_ref_clock_cfg
